// ### logic/acs_regs.vh
/*
 * register offsets, field positions, reset values and timing counts
 * for the conversion sequencer; assumes inclusion by bare name.
 */
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// printed register indices, not byte addresses
`define ACS_OFF_STATUS_CONTROL 12'h038
`define ACS_OFF_RESULT         12'h039
`define ACS_OFF_CLOCK          12'h03A
// byte addresses on the apb bus, four times the index
`define ACS_ADDR_STATUS_CONTROL 12'h0E0
`define ACS_ADDR_RESULT         12'h0E4
`define ACS_ADDR_CLOCK          12'h0E8
`define ACS_ADDR_PORT_DATA      12'h100
`define ACS_ADDR_PORT_DIR       12'h104
`define ACS_ADDR_PORT_READ      12'h108

// status/control fields
`define ACS_DONE_BIT     7
`define ACS_IRQ_EN_BIT   6
`define ACS_REPEAT_BIT   5
`define ACS_SEL_MSB      4
`define ACS_SEL_LSB      0
// clock register fields
`define ACS_PRESC_MSB    7
`define ACS_PRESC_LSB    5
`define ACS_SRC_BIT      4

// reset values, power-off code and channel count
`define ACS_SEL_RESET    5'h1F
`define ACS_SEL_OFF      5'h1F
`define ACS_CLK_RESET    8'h00
`define ACS_PRESC_RESET  3'h0
`define ACS_SRC_RESET    1'b0
`define ACS_NUM_CHAN     15

// conversion length in converter clock cycles
`define ACS_CONV_MIN     5'h10
`define ACS_CONV_CYCLES  5'h11

`endif

// ### logic/acs_clock_prescaler.v
/*
 * converter clock prescaler: produces a one-cycle tick on pclk at the
 * divided converter rate. assumes the source clock arrives as a tick
 * on pclk (bus clock = every cycle, crystal as a synchronised tick).
 */
`timescale 1ns/10ps
`default_nettype none

module acs_clock_prescaler (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       src_tick,
  input  wire [2:0] prescale,
  input  wire       restart,
  output reg        conv_tick
);

  reg  [3:0] div_count;  // source ticks seen in this period
  reg  [3:0] div_last;   // terminal count for the chosen ratio

  // decode the divide ratio, top bit set gives sixteen
  always @* begin
    case (prescale)
      3'h0:    div_last = 4'h0;
      3'h1:    div_last = 4'h1;
      3'h2:    div_last = 4'h3;
      3'h3:    div_last = 4'h7;
      default: div_last = 4'hF;
    endcase
  end

  // count source ticks and emit one converter tick per period
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= 4'h0;
      conv_tick <= 1'b0;
    end else if (restart) begin
      div_count <= 4'h0;
      conv_tick <= 1'b0;
    end else if (src_tick) begin
      if (div_count >= div_last) begin
        div_count <= 4'h0;
        conv_tick <= 1'b1;
      end else begin
        div_count <= div_count + 4'h1;
        conv_tick <= 1'b0;
      end
    end else begin
      conv_tick <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### logic/acs_sequencer.v
/*
 * conversion sequencer: apb register slave, channel mux and pin
 * takeover, single and repeat conversions, done flag and interrupt.
 * assumes an external successive-approximation core that presents an
 * 8-bit result on sar_result when the sequencer reports the end of a
 * conversion, and port logic that obeys the pin overrides.
 * crystal_clock and pin_in are asynchronous and pass two flops here;
 * stop_mode and the apb signals come from logic on pclk.
 */
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "acs_regs.vh"

module acs_sequencer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        crystal_clock,
  input  wire        stop_mode,
  input  wire [7:0]  sar_result,
  output reg         sar_sample,
  output reg  [14:0] selected_analog_input,
  output wire        analog_power_on,
  input  wire [14:0] pin_in,
  output wire [14:0] pin_out,
  output wire [14:0] pin_oe_n,
  output wire [14:0] pin_analog_mode,
  output wire        conv_irq
);

  // one-hot sequencer states
  localparam [2:0] ST_IDLE = 3'b001;  // no conversion running
  localparam [2:0] ST_CONV = 3'b010;  // counting converter clocks
  localparam [2:0] ST_HALT = 3'b100;  // stop mode, frozen

  // software-visible registers
  reg  [4:0]  input_select_field;     // channel select
  reg         repeat_convert_bit;     // continuous conversions
  reg         conv_irq_enable;        // interrupt enable
  reg         done_flag;              // conversion complete
  reg         irq_pending;            // latched interrupt request
  reg  [7:0]  result;                 // last conversion result
  reg  [2:0]  clock_prescale_field;   // divide ratio code
  reg         clock_source_select;    // 1 = bus clock, 0 = crystal
  reg  [14:0] port_data;              // port data latches
  reg  [14:0] port_dir;               // 1 = output

  // sequencer state
  reg  [2:0]  state;
  reg  [4:0]  conv_count;             // converter clocks in this conversion
  reg         resume;                 // stop ended with work pending

  // crystal clock synchroniser and edge detector
  reg         xtal_meta;
  reg         xtal_sync;
  reg         xtal_prev;
  reg  [14:0] pin_meta;               // first stage of pin sampling
  reg  [14:0] pin_sync;               // pins after two flops

  // a select code is live unless it is the power-off code
  function sel_live;
    input [4:0] sel;
    begin
      sel_live = (sel != `ACS_SEL_OFF);
    end
  endfunction

  // bus decodes, valid only in the access cycle
  wire        xfer     = psel & penable;
  wire        wr_ctrl  = xfer & pwrite & (paddr == `ACS_ADDR_STATUS_CONTROL);
  wire        rd_res   = xfer & ~pwrite & (paddr == `ACS_ADDR_RESULT);
  // a control write that names a live channel starts a conversion
  wire        wr_start = wr_ctrl & sel_live(pwdata[`ACS_SEL_MSB:`ACS_SEL_LSB]);
  wire        powered  = sel_live(input_select_field);
  wire        src_tick;
  wire        conv_tick;
  wire        conv_end;
  wire        restart;

  // decode of the select field into a one-hot channel vector
  function [14:0] chan_decode;
    input [4:0] sel;
    begin
      if (sel < `ACS_NUM_CHAN)
        chan_decode = 15'h0001 << sel;
      else
        chan_decode = 15'h0000;
    end
  endfunction

  wire [14:0] chan_vec = chan_decode(input_select_field);

  // apb always answers in the access cycle without wait states
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  assign analog_power_on = powered;
  assign conv_irq        = irq_pending & conv_irq_enable;

  // selected pin is an undriven converter input, others are port pins;
  // the latch and direction bits stay stored, so a pin released by the
  // converter returns at once to what software last wrote
  assign pin_analog_mode = chan_vec;
  assign pin_out         = port_data;
  assign pin_oe_n        = ~(port_dir & ~chan_vec);

  // source tick: bus clock every cycle, crystal on synchronised rise
  assign src_tick = clock_source_select ? 1'b1 : (xtal_sync & ~xtal_prev);

  // restart the divider whenever a conversion starts afresh, so every
  // conversion sees whole converter periods from its start
  assign restart  = wr_ctrl | (state != ST_CONV);
  // ticks 1..16 count up, the seventeenth tick ends the conversion
  assign conv_end = (state == ST_CONV) & conv_tick & (conv_count == `ACS_CONV_MIN);

  // converter clock divider, one tick per converter period
  acs_clock_prescaler u_prescaler (
    .pclk      (pclk),
    .presetn   (presetn),
    .src_tick  (src_tick),
    .prescale  (clock_prescale_field),
    .restart   (restart),
    .conv_tick (conv_tick)
  );

  // two-flop synchronisers for the crystal clock and the pins
  // only the second stage feeds logic; the first may be metastable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_meta <= 1'b0;
      xtal_sync <= 1'b0;
      xtal_prev <= 1'b0;
      pin_meta  <= 15'h0000;
      pin_sync  <= 15'h0000;
    end else begin
      xtal_meta <= crystal_clock;
      xtal_sync <= xtal_meta;
      xtal_prev <= xtal_sync;
      pin_meta  <= pin_in;
      pin_sync  <= pin_meta;
    end
  end

  // analog mux control, registered one-hot selection
  // one cycle behind the select field, zero while powered off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      selected_analog_input <= 15'h0000;
    else
      selected_analog_input <= chan_vec;
  end

  // software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_select_field   <= `ACS_SEL_RESET;
      repeat_convert_bit   <= 1'b0;
      conv_irq_enable      <= 1'b0;
      clock_prescale_field <= `ACS_PRESC_RESET;
      clock_source_select  <= `ACS_SRC_RESET;
      port_data            <= 15'h0000;
      port_dir             <= 15'h0000;
    end else if (xfer & pwrite) begin
      case (paddr)
        // control write: channel, repeat and interrupt enable
        `ACS_ADDR_STATUS_CONTROL: begin
          input_select_field <= pwdata[`ACS_SEL_MSB:`ACS_SEL_LSB];
          repeat_convert_bit <= pwdata[`ACS_REPEAT_BIT];
          conv_irq_enable    <= pwdata[`ACS_IRQ_EN_BIT];
        end
        // clock write: divide ratio and source
        `ACS_ADDR_CLOCK: begin
          clock_prescale_field <= pwdata[`ACS_PRESC_MSB:`ACS_PRESC_LSB];
          clock_source_select  <= pwdata[`ACS_SRC_BIT];
        end
        // latches are kept; the pin mask makes them inert while selected
        `ACS_ADDR_PORT_DATA: port_data <= pwdata[14:0];
        `ACS_ADDR_PORT_DIR:  port_dir  <= pwdata[14:0];
        default: ;
      endcase
    end
  end

  // done flag: set wins over a clearing read in the same cycle
  // with interrupts on the bit is plain storage written by software
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      done_flag <= 1'b0;
    else if (conv_end & ~conv_irq_enable)
      done_flag <= 1'b1;
    else if (wr_ctrl)
      done_flag <= pwdata[`ACS_IRQ_EN_BIT] & pwdata[`ACS_DONE_BIT];
    else if (rd_res & ~conv_irq_enable)
      done_flag <= 1'b0;
  end

  // interrupt request latch, set wins over clear
  // the pin is masked by the enable, and the latch only sets while it is on
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_pending <= 1'b0;
    else if (conv_end & conv_irq_enable)
      irq_pending <= 1'b1;
    else if (wr_ctrl | rd_res)
      irq_pending <= 1'b0;
  end

  // result register, overwritten by every completed conversion
  // sar_result is taken on the end cycle, no read handshake
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      result <= 8'h00;
    else if (conv_end)
      result <= sar_result;
  end

  // sequencer: start on write, count clocks, repeat or stop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      conv_count <= 5'h00;
      sar_sample <= 1'b0;
      resume     <= 1'b0;
    end else begin
      sar_sample <= 1'b0;
      case (state)
        ST_IDLE: begin
          // stop takes precedence over any start
          if (stop_mode) begin
            state <= ST_HALT;
          end else if (wr_start) begin
            state      <= ST_CONV;
            conv_count <= 5'h00;
            sar_sample <= 1'b1;
          end
        end
        ST_CONV: begin
          // freeze; only a repeat run picks up again after stop
          if (stop_mode) begin
            state  <= ST_HALT;
            resume <= repeat_convert_bit;
          end else if (wr_ctrl) begin
            // abandon and restart on the new channel, or power down
            if (wr_start) begin
              conv_count <= 5'h00;
              sar_sample <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end else if (!powered) begin
            state <= ST_IDLE;
          end else if (conv_end) begin
            // repeat mode runs back to back without a gap
            conv_count <= 5'h00;
            if (repeat_convert_bit) begin
              sar_sample <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end else if (conv_tick) begin
            conv_count <= conv_count + 5'h01;
          end
        end
        ST_HALT: begin
          if (!stop_mode) begin
            conv_count <= 5'h00;
            resume     <= 1'b0;
            // a control write in the exit cycle decides by itself
            if (wr_ctrl ? wr_start : (resume & powered)) begin
              state      <= ST_CONV;
              sar_sample <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        // an illegal code falls back to idle
        default: state <= ST_IDLE;
      endcase
    end
  end

  // apb read mux, answered in the access cycle
  // unmapped offsets and unused high bits read as zero
  always @* begin
    prdata = 32'h0000_0000;
    case (paddr)
      `ACS_ADDR_STATUS_CONTROL:
        prdata[7:0] = {done_flag, conv_irq_enable, repeat_convert_bit, input_select_field};
      `ACS_ADDR_RESULT:
        prdata[7:0] = result;
      `ACS_ADDR_CLOCK:
        prdata[7:0] = {clock_prescale_field, clock_source_select, 4'h0};
      `ACS_ADDR_PORT_DATA:
        prdata[14:0] = port_data;
      `ACS_ADDR_PORT_DIR:
        prdata[14:0] = port_dir;
      `ACS_ADDR_PORT_READ:
        // converter pin reads zero or the latch; others read pin or latch
        prdata[14:0] = (chan_vec & port_dir & port_data)
                     | (~chan_vec & port_dir & port_data)
                     | (~chan_vec & ~port_dir & pin_sync);
      default:
        prdata = 32'h0000_0000;
    endcase
  end

endmodule

`default_nettype wire

// ### tb/acs_sar_model.sv
/* far side of the sequencer: analog core result and the port pads.
   assumes the bench supplies the input level and outside pin levels. */
`timescale 1ns/10ps
`default_nettype none
module acs_sar_model (
  input  wire logic        pclk,
  input  wire logic        power_on,
  input  wire logic [7:0]  level,
  input  wire logic [14:0] ext,
  input  wire logic [14:0] pin_out,
  input  wire logic [14:0] pin_oe_n,
  output logic      [7:0]  sar_result,
  output logic      [14:0] pin_in
);
  logic [7:0] junk = 8'h00; // changing pattern while unpowered
  // an unpowered core returns nothing meaningful
  always @(posedge pclk) begin
    junk <= junk + 8'h3B;
  end
  assign sar_result = power_on ? level : junk;
  // a pad shows the port driver when enabled, else the outside level
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);
endmodule
`default_nettype wire

// ### tb/acs_sequencer_sva.sv
/* port checker for the conversion sequencer.
   assumes it is bound to the sequencer top module. */
`timescale 1ns/10ps
`default_nettype none
`include "acs_regs.vh"
module acs_sequencer_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        stop_mode,
  input wire logic        sar_sample,
  input wire logic [14:0] selected_analog_input,
  input wire logic        analog_power_on,
  input wire logic [14:0] pin_oe_n,
  input wire logic [14:0] pin_analog_mode,
  input wire logic        conv_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_any; // write taken this edge
  assign wr_any = psel && penable && pwrite;
  property p_one_chan; $onehot0(selected_analog_input); endproperty
  a_one_chan: assert property (p_one_chan) else $error("several channels routed");
  property p_mux_follow;
    pin_analog_mode == $past(pin_analog_mode) |-> selected_analog_input == pin_analog_mode;
  endproperty
  a_mux_follow: assert property (p_mux_follow) else $error("mux not on taken pin");
  property p_pin_taken; (pin_analog_mode & ~pin_oe_n) == 15'h0000; endproperty
  a_pin_taken: assert property (p_pin_taken) else $error("taken pin still driven");
  property p_power_off;
    !analog_power_on |-> pin_analog_mode == 15'h0000 ##1 selected_analog_input == 15'h0000;
  endproperty
  a_power_off: assert property (p_power_off) else $error("channel routed while off");
  property p_start;
    wr_any && paddr == `ACS_ADDR_STATUS_CONTROL && pwdata[4:0] != 5'h1F && !stop_mode
      |=> sar_sample;
  endproperty
  a_start: assert property (p_start) else $error("write did not start conversion");
  property p_irq_clear;
    wr_any && paddr == `ACS_ADDR_STATUS_CONTROL && !pwdata[6] |=> !conv_irq [*3];
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq survived control write");
  property p_stop_idle; stop_mode && $past(stop_mode) |-> !sar_sample; endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("conversion started in stop");
  property p_dir_write;
    wr_any && paddr == `ACS_ADDR_PORT_DIR
      |=> pin_oe_n == ~($past(pwdata[14:0]) & ~pin_analog_mode);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("pin enables wrong");
  c_start: cover property (sar_sample);
  c_irq: cover property ($rose(conv_irq));
  c_stop: cover property (stop_mode ##1 !stop_mode);
endmodule
`default_nettype wire

// ### tb/tb_adc_conversion_sequencer.sv
/* self-checking bench for the conversion sequencer over apb.
   assumes the sar model and checker files are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "acs_regs.vh"
`define ACS_CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_adc_conversion_sequencer;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, exp_v;
  logic        crystal_clock = 1'b0, stop_mode = 1'b0, pready, pslverr, sar_sample;
  logic        analog_power_on, conv_irq;
  logic [7:0]  level = 8'h00, sar_result, old;
  logic [14:0] ext = 15'h0000, sel_in, pin_in, pin_out, pin_oe_n, pin_mode, pd, dr;
  logic [31:0] q[$]; // expected read data, oldest first
  int          n_fail = 0, check_count = 0, cyc = 0;
  always #2.5 pclk = ~pclk;
  // crystal source ticks every eight bus cycles
  always #20 crystal_clock = ~crystal_clock;
  acs_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crystal_clock(crystal_clock), .stop_mode(stop_mode),
    .sar_result(sar_result), .sar_sample(sar_sample), .selected_analog_input(sel_in),
    .analog_power_on(analog_power_on), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_analog_mode(pin_mode), .conv_irq(conv_irq));
  acs_sar_model model (.pclk(pclk), .power_on(analog_power_on), .level(level), .ext(ext),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .sar_result(sar_result), .pin_in(pin_in));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // compare each completed read against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready) begin
      exp_v = q.pop_front();
      `ACS_CHK(prdata, exp_v)
    end
  end
  // one conversion of ch at d bus cycles per converter tick; f is {irq, repeat}
  task automatic conv(input logic [4:0] ch, input int d, input logic [1:0] f);
    level <= 8'($urandom);
    wr(`ACS_ADDR_STATUS_CONTROL, {24'h0, 1'b0, f, ch});
    repeat (15 * d) @(posedge pclk);
    rd(`ACS_ADDR_STATUS_CONTROL, {24'h0, 1'b0, f, ch});
    repeat (3 * d + 6) @(posedge pclk);
    @(negedge pclk);
    `ACS_CHK(sel_in, 15'(15'h1 << ch))
    `ACS_CHK(conv_irq, f[1])
    rd(`ACS_ADDR_STATUS_CONTROL, {24'h0, ~f[1], f, ch});
    rd(`ACS_ADDR_RESULT, {24'h0, level});
    @(negedge pclk);
    `ACS_CHK(conv_irq, 1'b0)
    if (!f[0]) rd(`ACS_ADDR_STATUS_CONTROL, {24'h0, 1'b0, f, ch});
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard well above the expected few thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(52449));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ACS_ADDR_STATUS_CONTROL, 32'h1F);
    rd(`ACS_ADDR_CLOCK, 32'h0);
    rd(12'h0F0, 32'h0);
    `ACS_CHK(analog_power_on, 1'b0)
    $display("reset test done");
    wr(`ACS_ADDR_CLOCK, 32'h10);
    for (int c = 0; c < 15; c++) conv(5'(c), 1, 2'b00);
    $display("channel test done");
    for (int p = 0; p < 8; p++) begin
      wr(`ACS_ADDR_CLOCK, {24'h0, 3'(p), 5'h10});
      conv(5'($urandom % 15), (p < 4) ? (1 << p) : 16, 2'b00);
    end
    wr(`ACS_ADDR_CLOCK, 32'h0);
    conv(5'h3, 8, 2'b00);
    wr(`ACS_ADDR_CLOCK, 32'h10);
    $display("clock test done");
    conv(5'h5, 1, 2'b01);
    level <= 8'($urandom);
    repeat (40) @(posedge pclk);
    rd(`ACS_ADDR_STATUS_CONTROL, 32'hA5);
    rd(`ACS_ADDR_RESULT, {24'h0, level});
    conv(5'h6, 1, 2'b11);
    level <= 8'($urandom);
    repeat (40) @(posedge pclk);
    @(negedge pclk);
    `ACS_CHK(conv_irq, 1'b1)
    rd(`ACS_ADDR_RESULT, {24'h0, level});
    old = level;
    stop_mode <= 1'b1;
    level <= ~old;
    repeat (60) @(posedge pclk);
    rd(`ACS_ADDR_RESULT, {24'h0, old});
    stop_mode <= 1'b0;
    repeat (60) @(posedge pclk);
    rd(`ACS_ADDR_RESULT, {24'h0, level});
    $display("repeat and stop test done");
    wr(`ACS_ADDR_STATUS_CONTROL, 32'h2);
    repeat (8) @(posedge pclk);
    conv(5'h7, 1, 2'b00);
    old = level;
    level <= ~old;
    repeat (40) @(posedge pclk);
    rd(`ACS_ADDR_RESULT, {24'h0, old});
    ext <= 15'($urandom);
    pd = 15'($urandom);
    dr = 15'($urandom);
    wr(`ACS_ADDR_PORT_DATA, {17'h0, pd});
    wr(`ACS_ADDR_PORT_DIR, {17'h0, dr});
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    `ACS_CHK(pin_oe_n, ~(dr & ~15'h0080))
    `ACS_CHK(pin_out & ~pin_oe_n, pd & dr & ~15'h0080)
    rd(`ACS_ADDR_PORT_READ, {17'h0, (dr & pd) | (~dr & ~15'h0080 & ext)});
    wr(`ACS_ADDR_STATUS_CONTROL, 32'h1F);
    @(negedge pclk);
    `ACS_CHK(analog_power_on, 1'b0)
    $display("port and power test done");
    give_verdict();
  end
endmodule
bind acs_sequencer acs_sequencer_sva chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .stop_mode, .sar_sample, .selected_analog_input, .analog_power_on, .pin_oe_n,
  .pin_analog_mode, .conv_irq);
`default_nettype wire
